/* File: shared/hsc_pkg.sv */
// Constants and types for the hub status/command register block.
// Assumes one core clock and byte transfers decoded by the serial slave.
package hsc_pkg;

  // ----------------------------------------------------------------
  // Layout
  // ----------------------------------------------------------------
  localparam int         DATA_W       = 8;
  localparam int         ADDR_W       = 8;
  localparam int         MEM_DEPTH    = 255;
  localparam logic [7:0] ADDR_STATUS  = 8'hFF;
  localparam int         BIT_SLEEP    = 2;
  localparam int         BIT_RESET    = 1;
  localparam int         BIT_ATTACH   = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PORT_ACTIVE,
    PORT_SLEEP_PENDING,
    PORT_ASLEEP
  } hsc_port_t;

  typedef struct packed {
    hsc_port_t   port;
    logic        portOff;
    logic        sleepBit;
    logic        attachBit;
    logic        softPending;
    logic [7:0]  rdData;
    logic        rdValid;
  } hsc_top_state_t;

endpackage : hsc_pkg

/* File: shared/hsc_mem_if.sv */
// Link between the status/command logic and the configuration memory.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface hsc_mem_if;
  logic                           wrEn;
  logic [7:0]                     addr;
  logic [7:0]                     wrData;
  logic                           reload;
  logic                           protect;
  logic [7:0]                     rdByte;
  logic [hsc_pkg::MEM_DEPTH*8-1:0] image;

  modport ctrl (output wrEn, output addr, output wrData, output reload,
                output protect, input rdByte, input image);
  modport mem  (input wrEn, input addr, input wrData, input reload,
                input protect, output rdByte, output image);
endinterface : hsc_mem_if

/* File: src/hsc_config_mem.sv */
// Configuration memory, locations 00h to FEh, with defaults and write protect.
// Assumes the controller never writes and reloads in the same cycle.
`timescale 1ns/1ps
module hsc_config_mem
  import hsc_pkg::*;
#(
  parameter logic [MEM_DEPTH*8-1:0] DEFAULTS    = '0,
  parameter logic [MEM_DEPTH-1:0]   MODIFY_MASK = '0
)(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Controller side
  hsc_mem_if.mem    mif
);

  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem;
  } hsc_mem_state_t;

  hsc_mem_state_t s;
  hsc_mem_state_t next_s;

  // ----------------------------------------------------------------
  // Update
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (mif.reload)
    begin
      next_s.mem = DEFAULTS;
    end
    else if (mif.wrEn && (mif.addr < ADDR_STATUS))
    begin
      // Modify-capable locations stay open after attach
      if (!mif.protect || MODIFY_MASK[mif.addr])
      begin
        next_s.mem[mif.addr] = mif.wrData;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s <= DEFAULTS;
    else
      s <= next_s;
  end

  assign mif.rdByte = (mif.addr < ADDR_STATUS) ? s.mem[mif.addr] : BYTE_ZERO;
  assign mif.image  = s.mem;

endmodule : hsc_config_mem

/* File: src/hsc_status_command.sv */
// Status/command register of the hub and its configuration memory.
// Assumes the serial slave hands over decoded byte accesses and an ack pulse.
//
// How it works
// - One 8-bit status/command byte sits at address FFh, bits 2..0 in use.
// - Setting the sleep bit powers the serial port down after the current ack.
// - Sleep and attach bits can only be set by writes; only rst clears them.
// - Writing 1 to bit 1 resets the serial port and reloads memory defaults.
// - The soft reset bit clears itself during the reset it starts.
// - With attach at 0 no attach is signalled; the serial port stays active unless the sleep bit is set.
// - With attach at 1 the hub signals attach upstream.
// - With attach at 1 non-modify-capable memory 00h..FEh is write protected.
// - All control bits read 0 after reset; reserved bits do nothing.
`timescale 1ns/1ps
module hsc_status_command
  import hsc_pkg::*;
#(
  parameter logic [MEM_DEPTH*8-1:0] DEFAULTS    = '0,
  parameter logic [MEM_DEPTH-1:0]   MODIFY_MASK = '0
)(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Byte access from the serial slave
  input  wire logic [hsc_pkg::ADDR_W-1:0]  accAddr,
  input  wire logic                        accWrite,
  input  wire logic [hsc_pkg::DATA_W-1:0]  accWrData,
  input  wire logic                        accRead,
  input  wire logic                        ackDone,
  // Read answer
  output logic      [hsc_pkg::DATA_W-1:0]  rdData,
  output logic                             rdValid,
  // Control outputs
  output logic                             configPortSleep,
  output logic                             usbAttach,
  output logic                             writeProtect,
  output logic                             serialIfReset,
  // Configuration image for the hub core
  output logic [hsc_pkg::MEM_DEPTH*8-1:0]  cfgImage
);

  import hsc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic setOnce(input logic cur, input logic wr);
    setOnce = cur | wr;
  endfunction : setOnce

  function automatic logic [7:0] statusByte(input hsc_top_state_t st);
    logic [7:0] b;
    b = STATUS_RESET;
    b[BIT_SLEEP]  = st.sleepBit;
    b[BIT_RESET]  = st.softPending;
    b[BIT_ATTACH] = st.attachBit;
    statusByte = b;
  endfunction : statusByte

  function automatic hsc_top_state_t statusWrite(input hsc_top_state_t st,
                                                 input logic [7:0]     d);
    hsc_top_state_t n;
    n = st;
    // Reserved bits 7..3 are ignored
    n.sleepBit    = setOnce(st.sleepBit, d[BIT_SLEEP]);
    n.attachBit   = setOnce(st.attachBit, d[BIT_ATTACH]);
    n.softPending = d[BIT_RESET];
    statusWrite = n;
  endfunction : statusWrite

  function automatic logic [7:0] readAnswer(input hsc_top_state_t st,
                                            input logic           stat,
                                            input logic [7:0]     memByte);
    readAnswer = stat ? statusByte(st) : memByte;
  endfunction : readAnswer

  function automatic logic portIsLive(input hsc_top_state_t st);
    // Accesses are dropped while asleep or in the soft reset cycle
    portIsLive = (st.port != PORT_ASLEEP) && !st.softPending;
  endfunction : portIsLive

  function automatic hsc_port_t portStep(input hsc_port_t cur,
                                         input logic      sleepSet,
                                         input logic      ack);
    hsc_port_t nxt;
    nxt = cur;
    case (cur)
      PORT_ACTIVE:
      begin
        // Attach alone never puts the port to sleep
        if (sleepSet)
          nxt = PORT_SLEEP_PENDING;
      end
      PORT_SLEEP_PENDING:
      begin
        // Wait for the ack that closes the current transfer
        if (ack)
          nxt = PORT_ASLEEP;
      end
      PORT_ASLEEP:
      begin
        // Only the external reset wakes the port again
        nxt = PORT_ASLEEP;
      end
      default:
      begin
        nxt = PORT_ACTIVE;
      end
    endcase
    portStep = nxt;
  endfunction : portStep

  // ----------------------------------------------------------------
  // Memory
  // ----------------------------------------------------------------
  // Defaults and mask pass straight through
  hsc_mem_if mif ();

  hsc_config_mem #(
    .DEFAULTS    (DEFAULTS),
    .MODIFY_MASK (MODIFY_MASK)
  ) u_mem (
    .clock (clock),
    .rst   (rst),
    .mif   (mif)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hsc_top_state_t s;
  hsc_top_state_t next_s;
  logic           live;
  logic           isStat;
  logic           wrStat;
  logic           wrMem;
  logic           rdTake;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign live   = portIsLive(s);
  assign isStat = (accAddr == ADDR_STATUS);
  // Memory writes never reach the status byte
  assign wrStat = live && accWrite && isStat;
  assign wrMem  = live && accWrite && !isStat;
  assign rdTake = live && accRead;

  // ----------------------------------------------------------------
  // Memory control
  // ----------------------------------------------------------------
  assign mif.addr    = accAddr;
  assign mif.wrData  = accWrData;
  assign mif.wrEn    = wrMem;
  assign mif.reload  = s.softPending;
  assign mif.protect = s.attachBit;

  always_comb
  begin
    // Pulses fall back to 0 unless set below
    next_s             = s;
    next_s.rdValid     = 1'b0;
    next_s.softPending = 1'b0;

    // Register writes
    if (wrStat)
    begin
      next_s = statusWrite(next_s, accWrData);
    end

    // Read answer
    if (rdTake)
    begin
      next_s.rdValid = 1'b1;
      next_s.rdData  = readAnswer(s, isStat, mif.rdByte);
    end

    // Port power
    next_s.port    = portStep(s.port, next_s.sleepBit, ackDone);
    next_s.portOff = (next_s.port == PORT_ASLEEP);
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      // Constants only, field by field
      s.port        <= PORT_ACTIVE;
      s.portOff     <= 1'b0;
      s.sleepBit    <= 1'b0;
      s.attachBit   <= 1'b0;
      s.softPending <= 1'b0;
      s.rdData      <= STATUS_RESET;
      s.rdValid     <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  assign rdData          = s.rdData;
  assign rdValid         = s.rdValid;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign configPortSleep = s.portOff;
  assign usbAttach       = s.attachBit;
  assign writeProtect    = s.attachBit;
  assign serialIfReset   = s.softPending;

  // ----------------------------------------------------------------
  // Configuration image
  // ----------------------------------------------------------------
  // Registered inside the memory, so it is a flop output as well
  assign cfgImage        = mif.image;

endmodule : hsc_status_command

/* File: tb/hsc_props.sv */
// Port checker for the status/command block.
// Assumes bind onto hsc_status_command.
`timescale 1ns/1ps
module hsc_props
  import hsc_pkg::*;
#(
  parameter logic [MEM_DEPTH-1:0] MODIFY_MASK = '0
)(
  // Inputs
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] accAddr,
  input wire logic       accWrite,
  input wire logic [7:0] accWrData,
  input wire logic       accRead,
  input wire logic       ackDone,
  // Outputs
  input wire logic [7:0] rdData,
  input wire logic       rdValid,
  input wire logic       configPortSleep,
  input wire logic       usbAttach,
  input wire logic       writeProtect,
  input wire logic       serialIfReset,
  input wire logic [MEM_DEPTH*8-1:0] cfgImage
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Accesses are refused while asleep or in soft reset
  wire taken  = !configPortSleep && !serialIfReset;
  wire wrStat = taken && accWrite && accAddr == ADDR_STATUS;
  wire wrLock = taken && accWrite && accAddr != ADDR_STATUS && writeProtect
                && !MODIFY_MASK[accAddr];
  a_read_answer: assert property (accRead && taken |=> rdValid)
    else $error("read lost");
  a_status_read: assert property (accRead && taken && accAddr == ADDR_STATUS
    |=> rdData[7:3] == 5'h00 && rdData[0] == $past(usbAttach)) else $error("bad status");
  a_sleep_wait: assert property ($rose(configPortSleep) |-> $past(ackDone))
    else $error("early sleep");
  a_sleep_hold: assert property (configPortSleep |=> configPortSleep)
    else $error("sleep cleared");
  a_attach_hold: assert property (usbAttach |=> usbAttach)
    else $error("attach cleared");
  a_attach_set: assert property (wrStat && accWrData[BIT_ATTACH] |=> usbAttach)
    else $error("no attach");
  a_attach_cause: assert property (!usbAttach && !(wrStat && accWrData[0]) |=> !usbAttach)
    else $error("stray attach");
  a_protect_tie: assert property (writeProtect == usbAttach)
    else $error("protect off");
  a_soft_start: assert property (wrStat && accWrData[BIT_RESET] |=> serialIfReset)
    else $error("no soft reset");
  a_soft_clear: assert property (serialIfReset |=> !serialIfReset)
    else $error("soft reset stuck");
  a_protect_hold: assert property (wrLock |=> $stable(cfgImage))
    else $error("protected byte changed");
endmodule : hsc_props

bind hsc_status_command hsc_props #(.MODIFY_MASK(MODIFY_MASK)) u_props (.clock(clock),
  .rst(rst), .accAddr(accAddr), .cfgImage(cfgImage),
  .accWrite(accWrite), .accWrData(accWrData), .accRead(accRead), .ackDone(ackDone),
  .rdData(rdData), .rdValid(rdValid), .configPortSleep(configPortSleep),
  .usbAttach(usbAttach), .writeProtect(writeProtect), .serialIfReset(serialIfReset));

/* File: tb/hsc_master_model.sv */
// Configuration master stand-in issuing byte accesses.
// Assumes reads answer at the taking edge itself.
`timescale 1ns/1ps
module hsc_master_model (
  // Clock
  input  wire logic       clock,
  // Access
  output logic      [7:0] accAddr,
  output logic            accWrite,
  output logic      [7:0] accWrData,
  output logic            accRead,
  output logic            ackDone,
  // Answer
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid
);
  initial {accAddr, accWrite, accWrData, accRead, ackDone} = '0;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {accAddr, accWrData, accWrite} <= {a, d, 1'h1};
    @(posedge clock);
    // Released lines invert, never hold the old value
    {accAddr, accWrData, accWrite} <= {~a, ~d, 1'h0};
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] q, output logic v);
    @(posedge clock);
    {accAddr, accRead} <= {a, 1'h1};
    @(posedge clock);
    {accAddr, accRead} <= {~a, 1'h0};
    #1;
    q = rdData;
    v = rdValid;
  endtask : rd
  task ack();
    @(posedge clock);
    ackDone <= 1'h1;
    @(posedge clock);
    ackDone <= 1'h0;
  endtask : ack
endmodule : hsc_master_model

/* File: tb/hsc_status_command_test.sv */
// Self-checking bench for the status/command register.
// Assumes the master model drives every access input.
`timescale 1ns/1ps
module hsc_status_command_test;
  import hsc_pkg::*;
  localparam logic [MEM_DEPTH*8-1:0] DEF = {MEM_DEPTH{8'h5A}};
  logic                   clock = 1'h0;
  logic                   rst   = 1'h1;
  logic [7:0]             accAddr, accWrData, rdData, q;
  logic                   accWrite, accRead, ackDone, rdValid, v;
  logic                   configPortSleep, usbAttach, writeProtect, serialIfReset;
  logic [MEM_DEPTH*8-1:0] cfgImage;
  int                     errors = 0;
  int                     checksDone = 0;
  int                     cyc = 0;
  hsc_status_command #(.DEFAULTS(DEF), .MODIFY_MASK(255'h10)) uut (.clock(clock),
    .rst(rst), .accAddr(accAddr), .accWrite(accWrite), .accWrData(accWrData),
    .accRead(accRead), .ackDone(ackDone), .rdData(rdData), .rdValid(rdValid),
    .configPortSleep(configPortSleep), .usbAttach(usbAttach),
    .writeProtect(writeProtect), .serialIfReset(serialIfReset), .cfgImage(cfgImage));
  hsc_master_model mst (.clock(clock), .accAddr(accAddr), .accWrite(accWrite),
    .accWrData(accWrData), .accRead(accRead), .ackDone(ackDone), .rdData(rdData),
    .rdValid(rdValid));
  always #5 clock = ~clock;
  task finish_test();
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // Ceiling well above the roughly 50 cycles the tests need
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      errors++;
      finish_test();
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    checksDone++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task rdc(input logic [7:0] a, input logic [7:0] e);
    mst.rd(a, q, v);
    chk({7'h00, v}, 8'h01);
    chk(q, e);
  endtask : rdc
  task reset();
    @(posedge clock);
    rst <= 1'h1;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
  endtask : reset
  initial
  begin
    reset();
    chk({5'h00, configPortSleep, usbAttach, writeProtect}, 8'h00);
    rdc(8'hFF, 8'h00);
    $display("reset test done");
    mst.wr(8'h03, 8'hC3);
    rdc(8'h03, 8'hC3);
    chk(cfgImage[31:24], 8'hC3);
    mst.wr(8'hFF, 8'hFA);
    #1 chk({7'h00, serialIfReset}, 8'h01);
    rdc(8'h03, 8'h5A);
    chk({7'h00, cfgImage === DEF}, 8'h01);
    rdc(8'hFF, 8'h00);
    $display("soft reset test done");
    mst.wr(8'hFF, 8'h01);
    #1 chk({6'h00, usbAttach, writeProtect}, 8'h03);
    mst.wr(8'hFF, 8'h00);
    mst.wr(8'h03, 8'h11);
    mst.wr(8'h04, 8'h22);
    rdc(8'hFF, 8'h01);
    rdc(8'h03, 8'h5A);
    rdc(8'h04, 8'h22);
    chk(cfgImage[39:32], 8'h22);
    $display("attach test done");
    mst.wr(8'hFF, 8'h04);
    rdc(8'hFF, 8'h05);
    chk({7'h00, configPortSleep}, 8'h00);
    mst.ack();
    #1 chk({7'h00, configPortSleep}, 8'h01);
    mst.rd(8'hFF, q, v);
    chk({7'h00, v}, 8'h00);
    reset();
    rdc(8'hFF, 8'h00);
    $display("sleep test done");
    finish_test();
  end
endmodule : hsc_status_command_test
